// ==== pio_pins_model.sv ====
// pin board model: driven pins read back their level, others the board.
// assumes: board level is set by the bench, pins resolve at once.
`timescale 1ns/100ps
`default_nettype none
module pio_pins_model (
	// drive from the bank
	input wire pio_pkg::pio_drive_t pin_drive,
	// level of undriven pins
	input wire logic [63:0] board_level,
	// level seen at the pins
	output logic [63:0] pin_in
);
	// undriven pins fall to the board level, never the last driven value
	assign pin_in = (pin_drive.level & pin_drive.enable)
		| (board_level & ~pin_drive.enable);
endmodule : pio_pins_model
`default_nettype wire

// ==== pio_pkg.sv ====
// pio_pkg: register map, field masks and bus types of the parallel port bank.
// assumes: included before pio_port_bank; all users write pio_pkg::name.
`default_nettype none
package pio_pkg;

	localparam int PIO_PORTS = 8;
	localparam int PIO_PW    = 8;
	localparam int PIO_PINS  = PIO_PORTS * PIO_PW;

	// register indices; the byte address on the bus is four times the index
	localparam logic [3:0] PIO_IDX_A_DATA = 4'h0;
	localparam logic [3:0] PIO_IDX_B_DATA = 4'h1;
	localparam logic [3:0] PIO_IDX_C_DATA = 4'h2;
	localparam logic [3:0] PIO_IDX_D_DATA = 4'h3;
	localparam logic [3:0] PIO_IDX_A_DIR  = 4'h4;
	localparam logic [3:0] PIO_IDX_B_DIR  = 4'h5;
	localparam logic [3:0] PIO_IDX_C_DIR  = 4'h6;
	localparam logic [3:0] PIO_IDX_D_DIR  = 4'h7;
	localparam logic [3:0] PIO_IDX_E_DATA = 4'h8;
	localparam logic [3:0] PIO_IDX_F_DATA = 4'h9;
	localparam logic [3:0] PIO_IDX_G_DATA = 4'ha;
	localparam logic [3:0] PIO_IDX_H_DATA = 4'hb;
	localparam logic [3:0] PIO_IDX_E_DIR  = 4'hc;
	localparam logic [3:0] PIO_IDX_F_DIR  = 4'hd;
	localparam logic [3:0] PIO_IDX_G_DIR  = 4'he;
	localparam logic [3:0] PIO_IDX_H_DIR  = 4'hf;

	localparam int PIO_ADDR_W = 8;
	localparam int PIO_IDX_LSB = 2;

	// port numbers inside the bank
	localparam int PIO_PORT_B = 1;
	localparam int PIO_PORT_C = 2;

	// implemented data bits per port, port a in the low byte
	localparam logic [63:0] PIO_DATA_MASK = 64'h03077fffff3fffff;
	// implemented direction bits; port c bit 7 is the clock-output enable
	localparam logic [63:0] PIO_DIR_MASK  = 64'h03077fffffbfffff;
	localparam logic [7:0]  PIO_DIR_RESET = 8'h00;

	localparam int PIO_CLKOUT_BIT = 7;
	localparam int PIO_CLKOUT_PIN = 2;

	// converter channel codes 0..7 land on port b pins 0..7
	localparam logic [4:0] PIO_CH_PORTB_LAST = 5'h07;

	localparam logic [1:0] PIO_RESP_OKAY   = 2'b00;
	localparam logic [1:0] PIO_RESP_SLVERR = 2'b10;

	// pin drive bundle, bit 8*p+n is pin n of port p
	typedef struct packed {
		logic [63:0] level;
		logic [63:0] enable;
	} pio_drive_t;

endpackage : pio_pkg

`default_nettype wire

// ==== pio_port_bank.sv ====
// pio_port_bank: eight parallel ports, fifty pins, behind an axi4-lite slave.
// assumes: pin levels arrive from outside and are synchronised here; the
// converter channel select comes from logic on clk_sys.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Fifty two-way pins in eight ports, each pin input or output.
// - Data A-D at 0-3, direction A-D at 4-7, data E-H 8-b, direction E-H c-f.
// - Port c data bits 7,6 read zero; direction bit 7 enables clock out.
// - Ports f, g, h implement only their low 7, 3, 2 bits.
// - Data latches keep their value through reset, undefined until written.
// - Direction bit one drives the pin; zero leaves it undriven.
// - Reset clears the direction bits of all eight ports, making every pin an input.
// - Data reads give the latch for outputs, the pin level for inputs.
// - Latch writes with strobe lane 0 set land in either direction; an input pin is not affected.
// - Converter channel select claims port b pins as analog channels.
// - Claimed port b bit reads zero as input, latch as output.
// - Claimed port b pins never drive; direction bit only steers reads.
// - Clock-output enable drives clock on port c pin 2; reset clears it.
module pio_port_bank (
	// clock and reset
	input  wire logic                          clk_sys,
	input  wire logic                          nrst,
	// axi4-lite write address and data
	input  wire logic [pio_pkg::PIO_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output var  logic                          s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output var  logic                          s_axi_wready,
	// axi4-lite write response
	output var  logic [1:0]                    s_axi_bresp,
	output var  logic                          s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	// axi4-lite read
	input  wire logic [pio_pkg::PIO_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output var  logic                          s_axi_arready,
	output var  logic [31:0]                   s_axi_rdata,
	output var  logic [1:0]                    s_axi_rresp,
	output var  logic                          s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// converter claim on port b
	input  wire logic                          converter_active,
	input  wire logic [4:0]                    converter_channel_select,
	// package pins
	input  wire logic [63:0]                   pin_in,
	output var pio_pkg::pio_drive_t            pin_drive
);

	logic       rst_s1_reg;
	logic       rst_n_reg;
	logic [63:0] pin_s1_reg;
	logic [63:0] pin_s2_reg;
	logic [7:0] data_reg [pio_pkg::PIO_PORTS];
	logic [7:0] dir_reg  [pio_pkg::PIO_PORTS];
	logic [7:0] read_val [pio_pkg::PIO_PORTS];
	logic [7:0] dirr_val [pio_pkg::PIO_PORTS];
	logic [7:0] adc_claim;
	logic [63:0] drive_lvl_next;
	logic [63:0] drive_en_next;
	logic       clk_div_reg;
	logic       clkout_en;

	logic                          aw_full_reg;
	logic                          w_full_reg;
	logic [pio_pkg::PIO_ADDR_W-1:0] aw_addr_reg;
	logic [7:0]                    w_data_reg;
	logic                          w_lane0_reg;
	logic                          do_write;
	logic                          wr_mapped;
	logic [3:0]                    wr_idx;
	logic [3:0]                    rd_idx;
	logic                          rd_mapped;
	logic [7:0]                    rd_word;

	// reset release
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rst_s1_reg <= 1'b0;
			rst_n_reg  <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n_reg  <= rst_s1_reg;
		end
	end

	// pins are asynchronous to clk_sys
	always_ff @(posedge clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			pin_s1_reg <= 64'h0;
			pin_s2_reg <= 64'h0;
		end else begin
			pin_s1_reg <= pin_in;
			pin_s2_reg <= pin_s1_reg;
		end
	end

	// converter codes above 7 belong to other channels
	always_comb begin
		adc_claim = 8'h00;
		if (converter_active &&
		    converter_channel_select <= pio_pkg::PIO_CH_PORTB_LAST) begin
			adc_claim[converter_channel_select[2:0]] = 1'b1;
		end
	end

	assign clkout_en = dir_reg[pio_pkg::PIO_PORT_C][pio_pkg::PIO_CLKOUT_BIT];

	// per-port read values and pin drive
	for (genvar p = 0; p < pio_pkg::PIO_PORTS; p++) begin : g_port
		localparam logic [7:0] DMASK = pio_pkg::PIO_DATA_MASK[8*p +: 8];
		localparam logic [7:0] RMASK = pio_pkg::PIO_DIR_MASK[8*p +: 8];
		logic [7:0] claim;
		logic [7:0] pin_dir;

		assign claim = (p == pio_pkg::PIO_PORT_B) ? adc_claim : 8'h00;

		// latch for outputs, pin for inputs, zero for claimed inputs
		assign read_val[p] = DMASK & ((dir_reg[p] & data_reg[p])
			| (~dir_reg[p] & ~claim & pin_s2_reg[8*p +: 8]));
		// c bit 6, f/g/h upper bits read zero
		assign dirr_val[p] = RMASK & dir_reg[p];

		// claimed pins ignore the direction bit for driving
		assign pin_dir = dir_reg[p] & DMASK & ~claim;

		for (genvar n = 0; n < pio_pkg::PIO_PW; n++) begin : g_pin
			if (p == pio_pkg::PIO_PORT_C && n == pio_pkg::PIO_CLKOUT_PIN) begin : g_ck
				// clock output overrides this pin's direction bit
				assign drive_en_next[8*p+n]  = clkout_en | pin_dir[n];
				assign drive_lvl_next[8*p+n] = clkout_en ? clk_div_reg
					: data_reg[p][n];
			end else begin : g_io
				assign drive_en_next[8*p+n]  = pin_dir[n];
				assign drive_lvl_next[8*p+n] = data_reg[p][n];
			end
		end
	end

	// clock output runs at half clk_sys so that the pin comes from a flop;
	// a direct clock on a data pin would skip the output register
	always_ff @(posedge clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			clk_div_reg <= 1'b0;
		end else begin
			clk_div_reg <= ~clk_div_reg;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			pin_drive.level  <= 64'h0;
			pin_drive.enable <= 64'h0;
		end else begin
			pin_drive.level  <= drive_lvl_next;
			pin_drive.enable <= drive_en_next;
		end
	end

	// write channel capture; address and data are taken in either order
	assign wr_idx    = aw_addr_reg[pio_pkg::PIO_IDX_LSB +: 4];
	assign wr_mapped = aw_addr_reg[pio_pkg::PIO_ADDR_W-1:6] == 2'b00;
	assign do_write  = aw_full_reg && w_full_reg && !s_axi_bvalid;

	always_ff @(posedge clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			aw_full_reg   <= 1'b0;
			s_axi_awready <= 1'b0;
			aw_addr_reg   <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_reg   <= 1'b1;
			s_axi_awready <= 1'b0;
			aw_addr_reg   <= s_axi_awaddr;
		end else if (do_write || !aw_full_reg) begin
			aw_full_reg   <= 1'b0;
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			w_full_reg   <= 1'b0;
			s_axi_wready <= 1'b0;
			w_data_reg   <= 8'h00;
			w_lane0_reg  <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_reg   <= 1'b1;
			s_axi_wready <= 1'b0;
			w_data_reg   <= s_axi_wdata[7:0];
			w_lane0_reg  <= s_axi_wstrb[0];
		end else if (do_write || !w_full_reg) begin
			w_full_reg   <= 1'b0;
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= pio_pkg::PIO_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_mapped ? pio_pkg::PIO_RESP_OKAY
				: pio_pkg::PIO_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// data latches have no reset and accept writes in any direction
	always_ff @(posedge clk_sys) begin
		if (do_write && wr_mapped && w_lane0_reg) begin
			unique case (wr_idx)
				pio_pkg::PIO_IDX_A_DATA, pio_pkg::PIO_IDX_B_DATA,
				pio_pkg::PIO_IDX_C_DATA, pio_pkg::PIO_IDX_D_DATA: begin
					data_reg[wr_idx[1:0]] <= w_data_reg
						& pio_pkg::PIO_DATA_MASK[8*wr_idx[1:0] +: 8];
				end
				pio_pkg::PIO_IDX_E_DATA, pio_pkg::PIO_IDX_F_DATA,
				pio_pkg::PIO_IDX_G_DATA, pio_pkg::PIO_IDX_H_DATA: begin
					data_reg[{1'b1, wr_idx[1:0]}] <= w_data_reg
						& pio_pkg::PIO_DATA_MASK[8*{1'b1, wr_idx[1:0]} +: 8];
				end
				default: begin
				end
			endcase
		end
	end

	// all direction bits, clock-output enable included, clear at reset
	always_ff @(posedge clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			for (int i = 0; i < pio_pkg::PIO_PORTS; i++) begin
				dir_reg[i] <= pio_pkg::PIO_DIR_RESET;
			end
		end else if (do_write && wr_mapped && w_lane0_reg) begin
			unique case (wr_idx)
				pio_pkg::PIO_IDX_A_DIR, pio_pkg::PIO_IDX_B_DIR,
				pio_pkg::PIO_IDX_C_DIR, pio_pkg::PIO_IDX_D_DIR: begin
					dir_reg[wr_idx[1:0]] <= w_data_reg
						& pio_pkg::PIO_DIR_MASK[8*wr_idx[1:0] +: 8];
				end
				pio_pkg::PIO_IDX_E_DIR, pio_pkg::PIO_IDX_F_DIR,
				pio_pkg::PIO_IDX_G_DIR, pio_pkg::PIO_IDX_H_DIR: begin
					dir_reg[{1'b1, wr_idx[1:0]}] <= w_data_reg
						& pio_pkg::PIO_DIR_MASK[8*{1'b1, wr_idx[1:0]} +: 8];
				end
				default: begin
				end
			endcase
		end
	end

	// read decode
	assign rd_idx    = s_axi_araddr[pio_pkg::PIO_IDX_LSB +: 4];
	assign rd_mapped = s_axi_araddr[pio_pkg::PIO_ADDR_W-1:6] == 2'b00;

	always_comb begin
		unique case (rd_idx)
			pio_pkg::PIO_IDX_A_DATA, pio_pkg::PIO_IDX_B_DATA,
			pio_pkg::PIO_IDX_C_DATA, pio_pkg::PIO_IDX_D_DATA: begin
				rd_word = read_val[rd_idx[1:0]];
			end
			pio_pkg::PIO_IDX_A_DIR, pio_pkg::PIO_IDX_B_DIR,
			pio_pkg::PIO_IDX_C_DIR, pio_pkg::PIO_IDX_D_DIR: begin
				rd_word = dirr_val[rd_idx[1:0]];
			end
			pio_pkg::PIO_IDX_E_DATA, pio_pkg::PIO_IDX_F_DATA,
			pio_pkg::PIO_IDX_G_DATA, pio_pkg::PIO_IDX_H_DATA: begin
				rd_word = read_val[{1'b1, rd_idx[1:0]}];
			end
			default: begin
				rd_word = dirr_val[{1'b1, rd_idx[1:0]}];
			end
		endcase
	end

	// one read at a time; the answer follows the address by one edge
	always_ff @(posedge clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= pio_pkg::PIO_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_mapped ? {24'h0, rd_word} : 32'h0;
			s_axi_rresp   <= rd_mapped ? pio_pkg::PIO_RESP_OKAY
				: pio_pkg::PIO_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

endmodule : pio_port_bank

`default_nettype wire

// ==== pio_port_bank_sva.sv ====
// checker: bus answer timing and pin drive of the port bank.
// assumes: bound onto pio_port_bank, sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module pio_port_bank_sva (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// bus
	input wire logic [pio_pkg::PIO_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// converter and pins
	input wire logic converter_active,
	input wire logic [4:0] converter_channel_select,
	input wire pio_pkg::pio_drive_t pin_drive
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	read_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer missing");
	read_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	unmapped_read_a: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr[7:6] != 2'b00 |=>
		s_axi_rresp == pio_pkg::PIO_RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	write_answer_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:3] s_axi_bvalid) else $error("write answer missing");
	write_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	upper_zero_a: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read upper bits set");
	no_phantom_a: assert property (
		(pin_drive.enable & ~pio_pkg::PIO_DATA_MASK) == 64'h0)
		else $error("missing pin driven");
	reset_inputs_a: assert property (
		$rose(nrst) |-> (pin_drive.enable == 64'h0) [*4])
		else $error("pin driven after reset");
	claim_release_a: assert property (
		converter_active && converter_channel_select < 5'h08 ##1
		$stable({converter_active, converter_channel_select})[*2]
		|-> !pin_drive.enable[{3'h1, converter_channel_select[2:0]}])
		else $error("claimed pin driven");
endmodule : pio_port_bank_sva
bind pio_port_bank pio_port_bank_sva i_pio_port_bank_sva (.clk_sys, .nrst,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.converter_active, .converter_channel_select, .pin_drive);
`default_nettype wire

// ==== test_parallel_io_port_bank.sv ====
// bench for the port bank: bus master tasks, queue of expected answers.
// assumes: package, bank, checker and pin model compiled before it.
`timescale 1ns/100ps
`default_nettype none
module test_parallel_io_port_bank;
	localparam logic [1:0] OK = pio_pkg::PIO_RESP_OKAY;
	logic clk_sys = 1'b0, nrst = 1'b0, cv_on = 1'b0, lv;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, lat, m, e, la, w;
	logic [31:0] wdata = 32'h0, s_axi_rdata;
	logic [3:0] wstrb = 4'h1;
	logic [4:0] cv_sel = 5'h00;
	logic [63:0] board = 64'h0, pin_in;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	pio_pkg::pio_drive_t pin_drive;
	logic [33:0] rq[$];
	logic [1:0] wq[$];
	int n_fail = 0, compares = 0, cyc = 0;

	pio_port_bank i_pio_port_bank (.clk_sys, .nrst, .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready, .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(rready),
		.converter_active(cv_on), .converter_channel_select(cv_sel),
		.pin_in, .pin_drive);
	pio_pins_model i_pio_pins_model (.pin_drive, .board_level(board), .pin_in);

	always #20 clk_sys = ~clk_sys;

	task automatic finish_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	task automatic chk(input string n, input logic [33:0] s, e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	function automatic logic [7:0] ad(input int p, input bit dir);
		logic [3:0] i;
		i = (p < 4) ? 4'(p) : 4'(p + 4);
		return {2'b00, i + (dir ? 4'h4 : 4'h0), 2'b00};
	endfunction : ad

	// handshakes are judged mid-cycle, where ready is settled
	task automatic wr(input logic [7:0] a, d, input logic [1:0] r);
		logic ta, tw, tb, da, dw, db;
		wq.push_back(r);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		{da, dw, db} = 3'b000;
		while (!(da && dw && db)) begin
			@(negedge clk_sys);
			ta = s_axi_awready && !da;
			tw = s_axi_wready && !dw;
			tb = s_axi_bvalid && !db;
			@(posedge clk_sys);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
			{da, dw, db} = {da | ta, dw | tw, db | tb};
		end
		// one idle edge so the next request never meets this release
		@(posedge clk_sys);
	endtask : wr

	task automatic rd(input logic [7:0] a, d, input logic [1:0] r);
		logic ta, tb, da, db;
		rq.push_back({r, 24'h0, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		{da, db} = 2'b00;
		while (!(da && db)) begin
			@(negedge clk_sys);
			ta = s_axi_arready && !da;
			tb = s_axi_rvalid && !db;
			@(posedge clk_sys);
			if (ta) arvalid <= 1'b0;
			if (tb) rready <= 1'b0;
			{da, db} = {da | ta, db | tb};
		end
		@(posedge clk_sys);
	endtask : rd

	always @(negedge clk_sys) begin
		if (s_axi_rvalid && rready)
			chk("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (s_axi_bvalid && bready)
			chk("bresp", {32'h0, s_axi_bresp}, {32'h0, wq.pop_front()});
	end

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			finish_test();
		end
	end

	initial begin
		void'($urandom(82499));
		board <= {$urandom, $urandom};
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		for (int p = 0; p < 8; p++) begin
			rd(ad(p, 1), 8'h00, OK);
		end
		for (int p = 0; p < 8; p++) begin
			lat = 8'($urandom);
			m = 8'($urandom) & pio_pkg::PIO_DATA_MASK[8*p+:8];
			// unimplemented direction bits are written too and must drop
			w = m | ~pio_pkg::PIO_DIR_MASK[8*p+:8];
			if (p == 0) la = lat;
			wr(ad(p, 0), lat, OK);
			e = board[8*p+:8] & pio_pkg::PIO_DATA_MASK[8*p+:8];
			rd(ad(p, 0), e, OK);
			wr(ad(p, 1), w, OK);
			e = ((lat & m) | (e & ~m)) & pio_pkg::PIO_DATA_MASK[8*p+:8];
			rd(ad(p, 0), e, OK);
			rd(ad(p, 1), m, OK);
			chk("enable", pin_drive.enable[8*p+:8], m);
			chk("level", pin_drive.level[8*p+:8] & m, lat & m);
		end
		wr(ad(1, 0), 8'ha5, OK);
		wr(ad(1, 1), 8'h0f, OK);
		cv_on <= 1'b1;
		for (int s = 0; s <= 8; s++) begin
			cv_sel <= 5'(s);
			m = (s < 8) ? ~(8'h01 << s) : 8'hff;
			e = (8'h05 | (board[15:8] & 8'hf0)) & (m | 8'h0f);
			rd(ad(1, 0), e, OK);
			chk("claim", pin_drive.enable[15:8], 8'h0f & m);
		end
		cv_on <= 1'b0;
		wr(ad(2, 1), 8'hc0, OK);
		rd(ad(2, 1), 8'h80, OK);
		@(negedge clk_sys);
		lv = pin_drive.level[18];
		repeat (4) begin
			@(negedge clk_sys);
			chk("clock out", {pin_drive.enable[18], pin_drive.level[18]},
				{1'b1, ~lv});
			lv = pin_drive.level[18];
		end
		@(posedge clk_sys);
		wstrb <= 4'h0;
		wr(ad(2, 1), 8'h00, OK);
		rd(ad(2, 1), 8'h80, OK);
		wstrb <= 4'h1;
		wr(8'h40, 8'h11, pio_pkg::PIO_RESP_SLVERR);
		rd(8'h40, 8'h00, pio_pkg::PIO_RESP_SLVERR);
		nrst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd(ad(2, 1), 8'h00, OK);
		rd(ad(0, 1), 8'h00, OK);
		wr(ad(0, 1), 8'hff, OK);
		rd(ad(0, 0), la, OK);
		finish_test();
	end
endmodule : test_parallel_io_port_bank
`default_nettype wire
